// ===== logic/lfm_defines.svh
// register map, field positions, reset values and timing counts
`ifndef LFM_DEFINES_SVH
`define LFM_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LFM_CTRL_OFS 8'h00
`define LFM_LIMIT_OFS 8'h04
`define LFM_STATUS_OFS 8'h08
`define LFM_CLEAR_OFS 8'h0c
`define LFM_DERATE_OFS 8'h10
`define LFM_CTRL_RST 16'h0000
`define LFM_LIMIT_RST 16'h0000
`define LFM_CLEAR_BIT 0
// ----------------------------------------
// timing: persistence filter
// ----------------------------------------
`define LFM_CLK_MHZ 50
`define LFM_FILT_NS 10000
`define LFM_FILT_CYC ((`LFM_FILT_NS * `LFM_CLK_MHZ + 999) / 1000)
// ----------------------------------------
// derating scale, quarter percent steps
// ----------------------------------------
`define LFM_DUTY_FULL 9'h190
`define LFM_DERATE_STEP 12'h009
`define LFM_ONSET_LO 8'h5a
`define LFM_ONSET_MID 8'h64
`define LFM_ONSET_HI 8'h6e
`endif

// ===== logic/lfm_pkg.sv
// shared types of the led fault manager
package lfm_pkg;
    typedef logic [11:0] lfm_mv_t;  // millivolts
    typedef logic [12:0] lfm_res_t; // resistance, 10 ohm units
    typedef struct packed {
        logic boost_at_max;     // adaptive boost at max voltage
        logic pump_low;         // charge pump voltage low
        logic boost_soft_start; // boost soft start reached
        logic normal_mode;      // device in normal operation
        logic recovery_done;    // recovery timer restarted device
        logic [3:0] short_hit;  // short detected per string
    } lfm_sense_t;
    typedef struct packed {
        logic [1:0] die_derate_onset_sel;
        logic [2:0] headroom_threshold_sel;
        logic hybrid_dim_en;
        logic thermistor_comp_en;
        logic cluster_string_fault_en;
        logic display_fault_en;
        logic cluster_mode;
    } lfm_ctrl_t;
    typedef enum logic [0:0] {
        LFM_RUN = 1'b0,
        LFM_RECOVER = 1'b1
    } lfm_state_t;
endpackage : lfm_pkg

// ===== logic/lfm_persist.sv
// persistence filter: output rises after input held for a count
`timescale 1ns/1ps
module lfm_persist #(
    parameter int CYCLES = 500 // cycles the input must persist
) (
    input wire logic clock, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic raw,   // unfiltered condition
    input wire logic active, // monitoring window open
    output logic hit        // filtered condition
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count;

    // count while condition holds, restart on any drop
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            hit <= 1'b0;
        end else if (!(raw && active)) begin
            count <= '0;
            hit <= 1'b0;
        end else if (count == CW'(CYCLES - 1)) begin
            hit <= 1'b1;
        end else begin
            count <= count + 1'b1;
        end
    end
endmodule : lfm_persist

// ===== logic/lfm_ntc_cmp.sv
// thermistor limit decode and compare
`timescale 1ns/1ps
module lfm_ntc_cmp (
    input wire logic clock, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic [3:0] sel, // limit code
    input wire lfm_pkg::lfm_res_t res, // measured resistance
    output logic crossed    // resistance below limit
);
    import lfm_pkg::*;
    lfm_res_t limit;

    // sixteen limits, 10 ohm units, hotter codes lower
    always_comb begin
        case (sel)
            4'h0: limit = 13'h1f1f;
            4'h1: limit = 13'h10ef;
            4'h2: limit = 13'h0ba1;
            4'h3: limit = 13'h08db;
            4'h4: limit = 13'h0726;
            4'h5: limit = 13'h05fe;
            4'h6: limit = 13'h0529;
            4'h7: limit = 13'h0488;
            4'h8: limit = 13'h040a;
            4'h9: limit = 13'h03a4;
            4'ha: limit = 13'h0351;
            4'hb: limit = 13'h030b;
            4'hc: limit = 13'h02d0;
            4'hd: limit = 13'h029d;
            4'he: limit = 13'h0271;
            default: limit = 13'h024b;
        endcase
    end

    // ntc resistance falls as temperature rises
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            crossed <= 1'b0;
        end else begin
            crossed <= res < limit;
        end
    end
endmodule : lfm_ntc_cmp

// ===== logic/lfm_fault_manager.sv
// fault supervision for a four-string led backlight driver
//
// How it works
// - display mode: open when below headroom and boost already at maximum
// - headroom code 110 is sat+175 mV, lower codes larger, 000 is sat+1000 mV
// - display-mode open string leaves regulation loop and its pwm stops
// - open reporting gated by display enable or cluster enable per mode
// - cluster mode: open whenever below headroom, no boost condition
// - cluster mode: open string pwm disabled, fault pin pulled low
// - open flag and pin clear on reset, clear write or select toggle
// - four-bit string fault field marks open or short, reset-only clear
// - charge pump monitored from boost soft start onward
// - pump fault enters recovery and pulls fault pin low
// - pump flag stays set after recovery restart until cleared
// - derate onset code: 00 off, 01 90C, 10 100C, 11 110C
// - above onset pwm duty drops 2.25 percent per degree
// - hybrid dimming also lowers led current for derating
// - thermistor codes map to sixteen limits from 79.67k down to 5.87k
// - thermistor limits checked only in normal mode with compensation on
// - low thermistor limit crossed reduces led current
// - low thermistor flag rising pulls fault pin low
// - high thermistor limit switches all outputs off, flags, pulls pin low
// - thermistor bit clears only if condition gone; pin clears always
// - pump and thermistor faults must persist 10 us
// - recovery: power switch, boost and sinks off, registers usable
`timescale 1ns/1ps
`include "lfm_defines.svh"
module lfm_fault_manager #(
    parameter int FILT_CYC = `LFM_FILT_CYC // fault persistence cycles
) (
    input wire logic clock, // 50 MHz core clock
    input wire logic rst_n, // power-on or enable reset
    input wire logic [7:0] reg_addr, // register address
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, next cycle
    input wire logic serial_select_n, // serial select pin
    input wire lfm_pkg::lfm_sense_t sense, // same-clock sense flags
    input wire lfm_pkg::lfm_mv_t [3:0] string_mv, // sink voltages
    input wire lfm_pkg::lfm_mv_t sat_mv, // sink saturation voltage
    input wire logic [7:0] die_temp_c, // die temperature
    input wire lfm_pkg::lfm_res_t ntc_res, // thermistor resistance
    output logic fault_pin_o, // fault pin level when driven
    output logic fault_pin_oe_n, // low pulls fault pin
    output logic [3:0] string_reg_exclude, // out of boost loop
    output logic [3:0] string_pwm_en, // pwm allowed per string
    output logic [8:0] pwm_duty_scale, // duty scale, 0.25 pct
    output logic [8:0] led_current_scale, // current scale
    output logic current_reduce, // thermistor low reduction
    output logic led_all_off, // thermistor high shutoff
    output logic power_switch_en, // power line switch
    output logic boost_en, // boost converter enable
    output logic sink_en // led current sinks enable
);
    import lfm_pkg::*;

    // ----------------------------------------
    // registers and bus slave
    // ----------------------------------------
    lfm_ctrl_t ctrl;
    logic [7:0] limit_sel;
    logic clr_wr;

    // software control writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= lfm_ctrl_t'(`LFM_CTRL_RST);
            limit_sel <= 8'(`LFM_LIMIT_RST);
        end else if (reg_wr && reg_addr == `LFM_CTRL_OFS) begin
            ctrl <= lfm_ctrl_t'(reg_wdata[9:0]);
        end else if (reg_wr && reg_addr == `LFM_LIMIT_OFS) begin
            limit_sel <= reg_wdata[7:0];
        end
    end

    assign clr_wr = reg_wr && reg_addr == `LFM_CLEAR_OFS && reg_wdata[`LFM_CLEAR_BIT];

    // ----------------------------------------
    // select pin sync and toggle detect
    // ----------------------------------------
    logic sel_q1, sel_q2, sel_q3;
    logic clr_any;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_q1 <= 1'b1;
            sel_q2 <= 1'b1;
            sel_q3 <= 1'b1;
        end else begin
            sel_q1 <= serial_select_n;
            sel_q2 <= sel_q1;
            sel_q3 <= sel_q2;
        end
    end

    assign clr_any = clr_wr || (sel_q2 ^ sel_q3);

    // ----------------------------------------
    // recovery state
    // ----------------------------------------
    lfm_state_t state, next_state;
    logic pump_hit, lo_hit, hi_hit;
    logic pump_hit_q, lo_hit_q, hi_hit_q;

    always_comb begin
        next_state = state;
        case (state)
            LFM_RUN: if (pump_hit && !pump_hit_q) next_state = LFM_RECOVER;
            LFM_RECOVER: if (sense.recovery_done) next_state = LFM_RUN;
            default: next_state = LFM_RUN;
        endcase
    end

    // recovery cuts power path; register port stays live
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= LFM_RUN;
            power_switch_en <= 1'b1;
            boost_en <= 1'b1;
            sink_en <= 1'b1;
        end else begin
            state <= next_state;
            power_switch_en <= next_state == LFM_RUN;
            boost_en <= next_state == LFM_RUN;
            sink_en <= next_state == LFM_RUN;
        end
    end

    // ----------------------------------------
    // open string detection
    // ----------------------------------------
    logic [11:0] margin_mv;
    logic [12:0] thr_mv;
    logic [3:0] below, det, open_seen, new_open;
    logic open_gate;

    // headroom margin above saturation
    always_comb begin
        case (ctrl.headroom_threshold_sel)
            3'h7: margin_mv = 12'h032;
            3'h6: margin_mv = 12'h0af;
            3'h5: margin_mv = 12'h12c;
            3'h4: margin_mv = 12'h1c2;
            3'h3: margin_mv = 12'h23f;
            3'h2: margin_mv = 12'h2bc;
            3'h1: margin_mv = 12'h36b;
            default: margin_mv = 12'h3e8;
        endcase
    end

    assign thr_mv = 13'(sat_mv) + 13'(margin_mv);
    // display needs boost at max, cluster does not
    assign open_gate = state == LFM_RUN && (ctrl.cluster_mode ? ctrl.cluster_string_fault_en
        : (ctrl.display_fault_en && sense.boost_at_max));

    for (genvar gi = 0; gi < 4; gi++) begin : g_str
        assign below[gi] = 13'(string_mv[gi]) < thr_mv;
    end

    assign det = below & {4{open_gate}};
    assign new_open = det & ~open_seen;

    // per-string latches, held until reset
    logic [3:0] string_fault;
    logic [3:0] excl;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            open_seen <= 4'h0;
            excl <= 4'h0;
            string_fault <= 4'h0;
        end else begin
            open_seen <= open_seen | det;
            excl <= excl | (det & {4{!ctrl.cluster_mode}});
            string_fault <= string_fault | det | sense.short_hit;
        end
    end

    // string outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            string_pwm_en <= 4'hf;
            string_reg_exclude <= 4'h0;
        end else begin
            string_pwm_en <= ~(open_seen | det);
            string_reg_exclude <= excl | (det & {4{!ctrl.cluster_mode}});
        end
    end

    // ----------------------------------------
    // filtered pump and thermistor faults
    // ----------------------------------------
    logic [1:0] ntc_cross;
    logic [2:0] f_raw, f_act, f_hit;
    logic ntc_active;

    assign ntc_active = sense.normal_mode && ctrl.thermistor_comp_en;

    for (genvar gn = 0; gn < 2; gn++) begin : g_ntc
        lfm_ntc_cmp u_cmp (
            .clock(clock),
            .rst_n(rst_n),
            .sel(limit_sel[gn*4 +: 4]),
            .res(ntc_res),
            .crossed(ntc_cross[gn])
        );
    end

    assign f_raw = {ntc_cross[1], ntc_cross[0], sense.pump_low};
    assign f_act = {ntc_active, ntc_active, sense.boost_soft_start && state == LFM_RUN};

    for (genvar gf = 0; gf < 3; gf++) begin : g_filt
        lfm_persist #(.CYCLES(FILT_CYC)) u_filt (
            .clock(clock),
            .rst_n(rst_n),
            .raw(f_raw[gf]),
            .active(f_act[gf]),
            .hit(f_hit[gf])
        );
    end

    assign pump_hit = f_hit[0];
    assign lo_hit = f_hit[1];
    assign hi_hit = f_hit[2];

    // ----------------------------------------
    // sticky flags and fault pin latch
    // ----------------------------------------
    logic open_flag, pump_flag, therm_lo_flag, therm_hi_flag;
    logic [3:0] pin_latch, pin_set;

    assign pin_set = {hi_hit && !hi_hit_q, lo_hit && !lo_hit_q,
        pump_hit && !pump_hit_q, |new_open};

    // set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pump_hit_q <= 1'b0;
            lo_hit_q <= 1'b0;
            hi_hit_q <= 1'b0;
            open_flag <= 1'b0;
            pump_flag <= 1'b0;
            therm_lo_flag <= 1'b0;
            therm_hi_flag <= 1'b0;
            pin_latch <= 4'h0;
        end else begin
            pump_hit_q <= pump_hit;
            lo_hit_q <= lo_hit;
            hi_hit_q <= hi_hit;
            open_flag <= |new_open || (open_flag && !clr_any);
            pump_flag <= pump_hit || (pump_flag && !clr_any);
            therm_lo_flag <= lo_hit || (therm_lo_flag && !clr_any);
            therm_hi_flag <= hi_hit || (therm_hi_flag && !clr_any);
            pin_latch <= pin_set | (pin_latch & {4{!clr_any}});
        end
    end

    // open-drain fault pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault_pin_o <= 1'b0;
            fault_pin_oe_n <= 1'b1;
        end else begin
            fault_pin_o <= 1'b0;
            fault_pin_oe_n <= !(|pin_latch);
        end
    end

    // thermistor actions follow the live filtered condition
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            current_reduce <= 1'b0;
            led_all_off <= 1'b0;
        end else begin
            current_reduce <= lo_hit;
            led_all_off <= hi_hit;
        end
    end

    // ----------------------------------------
    // die temperature derating
    // ----------------------------------------
    logic [7:0] onset_c;
    logic [11:0] cut;
    logic [8:0] next_duty;

    always_comb begin
        case (ctrl.die_derate_onset_sel)
            2'h1: onset_c = `LFM_ONSET_LO;
            2'h2: onset_c = `LFM_ONSET_MID;
            default: onset_c = `LFM_ONSET_HI;
        endcase
        cut = 12'(die_temp_c - onset_c) * `LFM_DERATE_STEP;
        if (ctrl.die_derate_onset_sel == 2'h0 || die_temp_c <= onset_c) begin
            next_duty = `LFM_DUTY_FULL;
        end else if (cut >= 12'(`LFM_DUTY_FULL)) begin
            next_duty = 9'h000;
        end else begin
            next_duty = `LFM_DUTY_FULL - cut[8:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_duty_scale <= `LFM_DUTY_FULL;
            led_current_scale <= `LFM_DUTY_FULL;
        end else begin
            pwm_duty_scale <= next_duty;
            led_current_scale <= ctrl.hybrid_dim_en ? next_duty : `LFM_DUTY_FULL;
        end
    end

    // ----------------------------------------
    // read port, unmapped reads zero
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else begin
            case (reg_addr)
                `LFM_CTRL_OFS: reg_rdata <= 16'(ctrl);
                `LFM_LIMIT_OFS: reg_rdata <= 16'(limit_sel);
                `LFM_STATUS_OFS: reg_rdata <= {6'h00, state == LFM_RECOVER, !fault_pin_oe_n,
                    string_fault, therm_hi_flag, therm_lo_flag, pump_flag, open_flag};
                `LFM_DERATE_OFS: reg_rdata <= 16'(pwm_duty_scale);
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_pump_rise;
        pump_hit && !pump_hit_q && state == LFM_RUN;
    endsequence
    sequence s_recover_out;
        state == LFM_RECOVER && !power_switch_en && !boost_en && !sink_en;
    endsequence

    a_pump_recover: assert property (s_pump_rise |=> s_recover_out ##1 !fault_pin_oe_n)
        else $error("pump fault did not enter recovery");
    a_pin_release: assert property (fault_pin_oe_n |-> pin_latch == 4'h0 || $past(pin_latch) == 4'h0)
        else $error("fault pin released with fault latched");
    a_open_pwm: assert property ((open_seen & string_pwm_en) == 4'h0)
        else $error("open string still has pwm");
    a_field_sticky: assert property (##1 (string_fault & $past(string_fault)) == $past(string_fault))
        else $error("string fault field lost a bit");
    a_open_clear: assert property (clr_any && new_open == 4'h0 |=> !open_flag)
        else $error("open flag survived a clear");
    a_therm_hold: assert property (clr_any && lo_hit |=> therm_lo_flag)
        else $error("thermistor flag cleared while present");
    a_therm_gate: assert property (!ntc_active [*2] |-> !lo_hit && !hi_hit)
        else $error("thermistor fault outside window");
    a_high_off: assert property ($rose(hi_hit) |=> led_all_off && therm_hi_flag ##1 !fault_pin_oe_n)
        else $error("high limit did not shut outputs");
    a_derate_off: assert property (ctrl.die_derate_onset_sel == 2'h0 [*2] |-> pwm_duty_scale == `LFM_DUTY_FULL)
        else $error("derating active while disabled");
    a_pump_window: assert property (!sense.boost_soft_start [*2] |-> !pump_hit)
        else $error("pump fault before soft start");
    a_pump_sticky: assert property (pump_flag && !clr_any |=> pump_flag)
        else $error("pump flag dropped without clear");
endmodule : lfm_fault_manager

// ===== sim/lfm_host.sv
// host model: register port master and serial select pin
`timescale 1ns/1ps
module lfm_host (
    input wire logic clock, // core clock
    input wire logic [15:0] reg_rdata, // read data from device
    output logic [7:0] reg_addr, // register address
    output logic [15:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic serial_select_n // select pin, idle high
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        serial_select_n = 1'b1;
    end
    // one-cycle write, data inverted once released
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // select pulse, each edge clears flags
    task automatic sel_toggle();
        @(posedge clock);
        serial_select_n <= 1'b0;
        repeat (4) @(posedge clock);
        serial_select_n <= 1'b1;
    endtask : sel_toggle
endmodule : lfm_host

// ===== sim/lfm_fault_manager_tb_top.sv
// self-checking bench of the led fault manager
`timescale 1ns/1ps
`include "lfm_defines.svh"
module lfm_fault_manager_tb_top;
    import lfm_pkg::*;
    localparam int FILT = 8; // shortened persistence count
    logic clock;
    logic rst_n;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic serial_select_n;
    lfm_sense_t sense;
    lfm_mv_t [3:0] string_mv;
    lfm_mv_t sat_mv;
    logic [7:0] die_temp_c;
    lfm_res_t ntc_res;
    logic fault_pin_o;
    logic fault_pin_oe_n;
    logic [3:0] string_reg_exclude;
    logic [3:0] string_pwm_en;
    logic [8:0] pwm_duty_scale;
    logic [8:0] led_current_scale;
    logic current_reduce;
    logic led_all_off;
    logic power_switch_en;
    logic boost_en;
    logic sink_en;
    int errors;
    int cmp_count;
    logic [15:0] st;
    logic [8:0] exp_duty;
    lfm_fault_manager #(.FILT_CYC(FILT)) i_lfm_fault_manager (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .serial_select_n(serial_select_n), .sense(sense),
        .string_mv(string_mv), .sat_mv(sat_mv), .die_temp_c(die_temp_c), .ntc_res(ntc_res),
        .fault_pin_o(fault_pin_o), .fault_pin_oe_n(fault_pin_oe_n),
        .string_reg_exclude(string_reg_exclude), .string_pwm_en(string_pwm_en),
        .pwm_duty_scale(pwm_duty_scale), .led_current_scale(led_current_scale),
        .current_reduce(current_reduce), .led_all_off(led_all_off),
        .power_switch_en(power_switch_en), .boost_en(boost_en), .sink_en(sink_en));
    lfm_host i_lfm_host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .serial_select_n(serial_select_n));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_n
    task automatic st_chk(input logic [15:0] mask, input logic [15:0] exp);
        i_lfm_host.rd(`LFM_STATUS_OFS, st);
        check(st & mask, exp);
    endtask : st_chk
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // watchdog, about 10k cycles, far beyond the expected run
    initial begin
        #200_000;
        errors++;
        report_and_stop();
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        sense = '0;
        string_mv = {4{12'h3e8}};
        sat_mv = 12'h0c8;
        die_temp_c = 8'h69;
        ntc_res = 13'h1f40;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        wait_n(1);
        check({12'h000, string_pwm_en}, 16'h000f);
        st_chk(16'hffff, 16'h0000);
        // derating onset sweep at 105 C, hybrid dimming on
        for (int c = 0; c < 4; c++) begin
            i_lfm_host.wr(`LFM_CTRL_OFS, 16'(c << 8) | 16'h0010);
            wait_n(3);
            exp_duty = (c == 0 || 105 <= 80 + 10 * c) ? 9'h190 : 9'(400 - 9 * (105 - 80 - 10 * c));
            check({7'h00, pwm_duty_scale}, {7'h00, exp_duty});
            check({7'h00, led_current_scale}, {7'h00, exp_duty});
            i_lfm_host.rd(`LFM_DERATE_OFS, st);
            check(st, {7'h00, exp_duty});
        end
        // display mode open, 375 mV threshold, string 1 sits exactly on it
        i_lfm_host.wr(`LFM_CTRL_OFS, 16'h00c2);
        string_mv[0] <= 12'h12c;
        string_mv[1] <= 12'h177;
        wait_n(4);
        st_chk(16'hffff, 16'h0000);
        sense.boost_at_max <= 1'b1;
        wait_n(4);
        st_chk(16'hffff, 16'h0111);
        check({12'h000, string_reg_exclude}, 16'h0001);
        check({12'h000, string_pwm_en}, 16'h000e);
        check({15'h0000, fault_pin_oe_n}, 16'h0000);
        check({15'h0000, fault_pin_o}, 16'h0000);
        i_lfm_host.wr(`LFM_CLEAR_OFS, 16'h0001);
        wait_n(3);
        st_chk(16'hffff, 16'h0010);
        check({15'h0000, fault_pin_oe_n}, 16'h0001);
        // cluster mode: gated off, then enabled without boost at max
        sense.boost_at_max <= 1'b0;
        i_lfm_host.wr(`LFM_CTRL_OFS, 16'h00c1);
        string_mv[2] <= 12'h12c;
        wait_n(4);
        st_chk(16'hffff, 16'h0010);
        i_lfm_host.wr(`LFM_CTRL_OFS, 16'h00c5);
        wait_n(4);
        st_chk(16'hffff, 16'h0151);
        check({12'h000, string_pwm_en}, 16'h000a);
        check({15'h0000, fault_pin_oe_n}, 16'h0000);
        i_lfm_host.sel_toggle();
        wait_n(6);
        st_chk(16'hffff, 16'h0050);
        check({15'h0000, fault_pin_oe_n}, 16'h0001);
        // pump: ignored before soft start, short glitch filtered, then fault
        sense.pump_low <= 1'b1;
        wait_n(FILT + 4);
        st_chk(16'h0202, 16'h0000);
        sense.pump_low <= 1'b0;
        sense.boost_soft_start <= 1'b1;
        @(posedge clock);
        sense.pump_low <= 1'b1;
        wait_n(FILT - 3);
        sense.pump_low <= 1'b0;
        wait_n(4);
        st_chk(16'h0202, 16'h0000);
        sense.pump_low <= 1'b1;
        wait_n(FILT + 4);
        st_chk(16'h0202, 16'h0202);
        check({13'h0000, power_switch_en, boost_en, sink_en}, 16'h0000);
        check({15'h0000, fault_pin_oe_n}, 16'h0000);
        sense.pump_low <= 1'b0;
        sense.recovery_done <= 1'b1;
        @(posedge clock);
        sense.recovery_done <= 1'b0;
        wait_n(3);
        st_chk(16'h0202, 16'h0002);
        check({13'h0000, power_switch_en, boost_en, sink_en}, 16'h0007);
        // thermistor: high code 0 limit crossed, low code f not
        sense.normal_mode <= 1'b1;
        i_lfm_host.wr(`LFM_LIMIT_OFS, 16'h000f);
        i_lfm_host.wr(`LFM_CTRL_OFS, 16'h0000);
        ntc_res <= 13'h03e8;
        wait_n(FILT + 4);
        st_chk(16'h000c, 16'h0000);
        i_lfm_host.wr(`LFM_CLEAR_OFS, 16'h0001);
        i_lfm_host.wr(`LFM_CTRL_OFS, 16'h0008);
        wait_n(FILT + 4);
        st_chk(16'h000e, 16'h0008);
        check({14'h0000, led_all_off, current_reduce}, 16'h0002);
        check({15'h0000, fault_pin_oe_n}, 16'h0000);
        i_lfm_host.wr(`LFM_CLEAR_OFS, 16'h0001);
        wait_n(3);
        st_chk(16'h0008, 16'h0008);
        check({15'h0000, fault_pin_oe_n}, 16'h0001);
        // below the low limit too, then both conditions gone
        ntc_res <= 13'h01f4;
        wait_n(FILT + 4);
        st_chk(16'h000c, 16'h000c);
        check({14'h0000, led_all_off, current_reduce}, 16'h0003);
        check({15'h0000, fault_pin_oe_n}, 16'h0000);
        ntc_res <= 13'h1f40;
        wait_n(FILT + 4);
        i_lfm_host.wr(`LFM_CLEAR_OFS, 16'h0001);
        wait_n(3);
        st_chk(16'hffff, 16'h0050);
        // short on string 3 joins the per-string field
        sense.short_hit <= 4'h8;
        wait_n(1);
        sense.short_hit <= 4'h0;
        st_chk(16'hffff, 16'h00d0);
        // mid-run reset clears the field, flags and string outputs
        rst_n <= 1'b0;
        wait_n(2);
        rst_n <= 1'b1;
        wait_n(1);
        st_chk(16'hffff, 16'h0000);
        check({12'h000, string_pwm_en}, 16'h000f);
        check({15'h0000, fault_pin_oe_n}, 16'h0001);
        i_lfm_host.rd(8'hfc, st);
        check(st, 16'h0000);
        report_and_stop();
    end
endmodule : lfm_fault_manager_tb_top
